// [logic/scd_pkg.sv]
/*
 * Constants and types for the strap configuration decoder.
 * Assumes straps are board tie-offs, static once initialisation starts.
 */
// Functional notes
// - Resolution code selects auto TFT setup target
// - Drive strap picks low or high drive
// - Polarity strap picks pixel clock output edge
// - Host bus pair picks protocol, 01 reserved
// - 1bpp ratio codes give 4, 8, 16
// - 2bpp ratio codes give 8, 16, 32
// - 4bpp ratio codes give 16, 32, 64
// - Panel type picks pixel or shift clock
package scd_pkg;
	// Panel resolution codes
	localparam logic [2:0] SCD_RES_MANUAL = 3'h0;
	localparam logic [2:0] SCD_RES_QVGA = 3'h1;
	localparam logic [2:0] SCD_RES_WQVGA = 3'h2;
	localparam logic [2:0] SCD_RES_VGA = 3'h3;
	localparam logic [2:0] SCD_RES_WVGA = 3'h4;
	// Panel sizes, indexed by resolution code
	localparam logic [9:0] SCD_WIDTH_1 = 10'h140;
	localparam logic [9:0] SCD_WIDTH_2 = 10'h1e0;
	localparam logic [9:0] SCD_WIDTH_3 = 10'h280;
	localparam logic [9:0] SCD_WIDTH_4 = 10'h320;
	localparam logic [9:0] SCD_HEIGHT_1 = 10'h0f0;
	localparam logic [9:0] SCD_HEIGHT_2 = 10'h110;
	localparam logic [9:0] SCD_HEIGHT_3 = 10'h1e0;
	localparam logic [9:0] SCD_HEIGHT_4 = 10'h1e0;
	// Ratio as log2, base ratio 4:1 at 1bpp
	localparam logic [2:0] SCD_RATIO_LOG_BASE = 3'h2;
	localparam logic [1:0] SCD_RATIO_RESERVED = 2'h3;
	localparam logic [1:0] SCD_DEPTH_RESERVED = 2'h3;
	// Host bus protocol
	typedef enum logic [1:0] {
		SCD_BUS_GENERIC = 2'h0,
		SCD_BUS_RESERVED = 2'h1,
		SCD_BUS_ESTROBE = 2'h2,
		SCD_BUS_ASTROBE = 2'h3
	} scd_bus_t;
	// Loader states, Gray along the path
	typedef enum logic [1:0] {
		SCD_ST_RESET = 2'h0,
		SCD_ST_SAMPLE = 2'h1,
		SCD_ST_HOLD = 2'h3
	} scd_state_t;
	// Synchroniser settle cycles before sampling
	localparam logic [1:0] SCD_SETTLE_CYCLES = 2'h2;
	localparam int SCD_STRAP_W = 11;
endpackage : scd_pkg

// [logic/scd_strap_sync.sv]
/*
 * Two-flop synchroniser for the strap bundle.
 * Assumes straps arrive from pins, outside the clock domain.
 */
`timescale 1ns/100ps
module scd_strap_sync (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_srst,
	// Pin side
	input wire logic [scd_pkg::SCD_STRAP_W-1:0] i_pins,
	// Synchronised side
	output logic [scd_pkg::SCD_STRAP_W-1:0] o_sync
);
	import scd_pkg::*;
	logic [SCD_STRAP_W-1:0] meta_q; // First stage, read only by second

	// Two stages, reset to all low
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			meta_q <= '0;
			o_sync <= '0;
		end else begin
			meta_q <= i_pins;
			o_sync <= meta_q;
		end
	end
endmodule : scd_strap_sync

// [logic/scd_strap_decode.sv]
/*
 * Strap configuration decoder: catches the straps once after reset and
 * turns them into panel, host bus and shift clock settings.
 * Assumes straps are tied on the board and colour depth and panel type
 * come from register logic on the same clock.
 */
`timescale 1ns/100ps
module scd_strap_decode (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_srst,
	// Strap pins
	input wire logic i_auto_setup_strap,
	input wire logic i_drive_strength_strap,
	input wire logic i_clock_polarity_strap,
	input wire logic [2:0] i_panel_resolution_strap,
	input wire logic i_addressing_mode_strap,
	input wire logic [1:0] i_host_bus_select_strap,
	input wire logic [1:0] i_line_clock_ratio_strap,
	// Register settings
	input wire logic [1:0] i_colour_depth_field,
	input wire logic i_panel_type_select,
	// Status
	output logic o_config_valid,
	// Panel setup
	output logic o_auto_setup_en,
	output logic [2:0] o_panel_resolution,
	output logic [9:0] o_panel_width,
	output logic [9:0] o_panel_height,
	output logic o_tft_drive_high,
	output logic o_tft_change_rising,
	// Host bus
	output logic o_indirect_addr,
	output scd_pkg::scd_bus_t o_host_bus,
	// Shift clock
	output logic o_clock_is_tft,
	output logic [2:0] o_shift_ratio_log2,
	output logic o_shift_ratio_valid,
	// Reserved code flags
	output logic o_resolution_reserved,
	output logic o_bus_reserved,
	output logic o_ratio_reserved
);
	import scd_pkg::*;

	logic [SCD_STRAP_W-1:0] pins; // Strap bundle at the pins
	logic [SCD_STRAP_W-1:0] sync; // After two flops
	logic [SCD_STRAP_W-1:0] latch_q; // Captured once, then held
	scd_state_t state_q;
	scd_state_t state_d;
	logic [1:0] settle_q; // Cycles of synchroniser settling
	logic [1:0] settle_d;

	// Decoded fields of the captured straps
	wire auto_bit = latch_q[10];
	wire drive_bit = latch_q[9];
	wire pol_bit = latch_q[8];
	wire [2:0] res_code = latch_q[7:5];
	wire addr_bit = latch_q[4];
	wire [1:0] bus_code = latch_q[3:2];
	wire [1:0] ratio_code = latch_q[1:0];

	// Auto setup needs a known resolution code
	function automatic logic res_known(input logic [2:0] code);
		res_known = (code >= SCD_RES_QVGA) && (code <= SCD_RES_WVGA);
	endfunction : res_known

	assign pins = {i_auto_setup_strap, i_drive_strength_strap, i_clock_polarity_strap,
		i_panel_resolution_strap, i_addressing_mode_strap, i_host_bus_select_strap,
		i_line_clock_ratio_strap};

	// Pins pass two flops before any decode
	scd_strap_sync u_sync (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.i_pins(pins),
		.o_sync(sync)
	);

	// Sample once after the synchroniser has filled, then hold
	wire settled = (settle_q == SCD_SETTLE_CYCLES);
	always_comb begin
		state_d = state_q;
		settle_d = settle_q;
		unique case (state_q)
			SCD_ST_RESET: begin
				settle_d = settle_q + 2'h1;
				if (settled) begin
					state_d = SCD_ST_SAMPLE;
				end
			end
			SCD_ST_SAMPLE: begin
				state_d = SCD_ST_HOLD;
			end
			SCD_ST_HOLD: begin
				state_d = SCD_ST_HOLD; // Never leaves; straps are static
			end
			default: begin
				state_d = SCD_ST_RESET;
			end
		endcase
	end

	// State and settle counter
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			state_q <= SCD_ST_RESET;
			settle_q <= 2'h0;
		end else begin
			state_q <= state_d;
			settle_q <= settle_d;
		end
	end

	// Capture only in the sample state; later changes are ignored
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			latch_q <= '0;
		end else if (state_q == SCD_ST_SAMPLE) begin
			latch_q <= sync;
		end
	end

	// Auto setup is on for a supported resolution code only
	wire auto_on = auto_bit && res_known(res_code);
	assign o_config_valid = (state_q == SCD_ST_HOLD);
	assign o_auto_setup_en = o_config_valid && auto_on;
	assign o_panel_resolution = auto_on ? res_code : SCD_RES_MANUAL;
	assign o_resolution_reserved = o_config_valid && auto_bit && !res_known(res_code);

	// Panel size lookup
	assign o_panel_width = (res_code == SCD_RES_QVGA) ? SCD_WIDTH_1 :
		(res_code == SCD_RES_WQVGA) ? SCD_WIDTH_2 :
		(res_code == SCD_RES_VGA) ? SCD_WIDTH_3 :
		(res_code == SCD_RES_WVGA) ? SCD_WIDTH_4 : 10'h000;
	assign o_panel_height = (res_code == SCD_RES_QVGA) ? SCD_HEIGHT_1 :
		(res_code == SCD_RES_WQVGA) ? SCD_HEIGHT_2 :
		(res_code == SCD_RES_VGA) ? SCD_HEIGHT_3 :
		(res_code == SCD_RES_WVGA) ? SCD_HEIGHT_4 : 10'h000;

	// Drive and edge straps only count in auto setup; board ties them low for the manual resolution code
	assign o_tft_drive_high = o_auto_setup_en && drive_bit;
	assign o_tft_change_rising = o_auto_setup_en && pol_bit;

	// Host addressing and protocol
	assign o_indirect_addr = addr_bit;
	assign o_host_bus = scd_bus_t'(bus_code);
	assign o_bus_reserved = o_config_valid && (bus_code == SCD_BUS_RESERVED);

	// Shared clock output role follows panel type
	assign o_clock_is_tft = i_panel_type_select;

	// Ratio log2 = base + depth + code; 4:1 doubles per step
	wire ratio_bad = (ratio_code == SCD_RATIO_RESERVED) || (i_colour_depth_field == SCD_DEPTH_RESERVED);
	wire [2:0] ratio_sum = SCD_RATIO_LOG_BASE + {1'b0, i_colour_depth_field} + {1'b0, ratio_code};
	// TFT mode expects the pair at 00, so ratio is unused there
	wire stn_mode = !i_panel_type_select;
	assign o_shift_ratio_log2 = ratio_bad ? 3'h0 : ratio_sum;
	assign o_shift_ratio_valid = o_config_valid && stn_mode && !ratio_bad;
	assign o_ratio_reserved = o_config_valid && stn_mode && ratio_bad;

	// Checks
	hold_stable_a: assert property (@(posedge i_clk) disable iff (i_srst)
		o_config_valid |=> $stable(latch_q) && o_config_valid)
		else $error("straps changed after capture");
	valid_time_a: assert property (@(posedge i_clk) disable iff (i_srst)
		$fell(i_srst) |-> !o_config_valid ##4 o_config_valid)
		else $error("capture timing wrong");
	drive_gate_a: assert property (@(posedge i_clk) disable iff (i_srst)
		o_tft_drive_high |-> o_auto_setup_en && latch_q[9])
		else $error("drive high without auto setup");
	edge_gate_a: assert property (@(posedge i_clk) disable iff (i_srst)
		o_auto_setup_en |-> o_tft_change_rising == latch_q[8])
		else $error("edge select wrong");
	res_manual_a: assert property (@(posedge i_clk) disable iff (i_srst)
		(o_config_valid && latch_q[7:5] == 3'h0) |-> !o_auto_setup_en && o_panel_resolution == 3'h0)
		else $error("manual code enabled auto setup");
	bus_reserved_a: assert property (@(posedge i_clk) disable iff (i_srst)
		o_bus_reserved |-> o_host_bus == SCD_BUS_RESERVED)
		else $error("reserved bus flag wrong");
	addr_mode_a: assert property (@(posedge i_clk) disable iff (i_srst)
		o_config_valid |-> o_indirect_addr == latch_q[4])
		else $error("addressing mode wrong");
	ratio_1bpp_a: assert property (@(posedge i_clk) disable iff (i_srst)
		(o_shift_ratio_valid && i_colour_depth_field == 2'h0 && latch_q[1:0] == 2'h0) |-> o_shift_ratio_log2 == 3'h2)
		else $error("1bpp ratio wrong");
	ratio_2bpp_a: assert property (@(posedge i_clk) disable iff (i_srst)
		(o_shift_ratio_valid && i_colour_depth_field == 2'h1 && latch_q[1:0] == 2'h2) |-> o_shift_ratio_log2 == 3'h5)
		else $error("2bpp ratio wrong");
	ratio_4bpp_a: assert property (@(posedge i_clk) disable iff (i_srst)
		(o_shift_ratio_valid && i_colour_depth_field == 2'h2 && latch_q[1:0] == 2'h2) |-> o_shift_ratio_log2 == 3'h6)
		else $error("4bpp ratio wrong");
	clk_role_a: assert property (@(posedge i_clk) disable iff (i_srst)
		o_shift_ratio_valid |-> !o_clock_is_tft)
		else $error("ratio valid in TFT mode");
	auto_cov: cover property (@(posedge i_clk) disable iff (i_srst) o_auto_setup_en && o_tft_drive_high);
	stn_cov: cover property (@(posedge i_clk) disable iff (i_srst) o_shift_ratio_valid);
	resv_cov: cover property (@(posedge i_clk) disable iff (i_srst) o_bus_reserved);
endmodule : scd_strap_decode

// [tb/scd_strap_board.sv]
/*
 * Board strap model: ties the strap pins to the levels the bench asks for.
 * Assumes the bench loads a new bundle only while it means the pins to move.
 */
`timescale 1ns/100ps
module scd_strap_board (
	// Bench side
	input wire logic i_load,
	input wire logic [10:0] i_req,
	input wire logic i_tft,
	// Strap pins
	output logic [10:0] o_straps
);
	logic [10:0] tie_d; // Bundle after board tie-offs
	// Manual resolution code ties drive and polarity low; TFT ties the ratio pair low
	assign tie_d = {i_req[10], i_req[9:8] & {2{i_req[7:5] != 3'h0}}, i_req[7:2], i_req[1:0] & {2{!i_tft}}};
	// Pins only move on a load, like a rework of the tie-offs; runs at time zero too
	always_latch begin
		if (i_load) begin
			o_straps <= tie_d;
		end
	end
endmodule : scd_strap_board

// [tb/tb_top.sv]
/*
 * Self-checking bench for the strap decoder.
 * Assumes one capture per reset, flagged by o_config_valid.
 */
`timescale 1ns/100ps
module tb_top;
	import scd_pkg::*;
	logic i_clk = 1'b0; // 200 MHz clock
	logic i_srst = 1'b1; // Sync reset
	logic load = 1'b1; // Board may move pins
	logic [10:0] req = 11'h0; // Requested bundle
	logic [10:0] straps; // Pin levels
	logic [1:0] depth = 2'h0; // Live colour depth
	logic ptype = 1'b0; // Live panel type
	logic probe = 1'b0; // Result due at next edge
	logic [37:0] notes[$]; // Expected results, oldest first
	int mismatches = 0;
	int cmp_count = 0;
	logic valid, auto_en, drv, pol, ind, tft_o, rv, rsr, bsr, rar;
	logic [2:0] res, rlog;
	logic [9:0] wid, hgt;
	scd_bus_t bus;
	wire logic [37:0] seen = {valid, auto_en, res, wid, hgt, drv, pol, ind, bus, tft_o, rlog, rv, rsr, bsr, rar};
	// Half period of 2.5 ns
	always #2.5 i_clk = ~i_clk;
	scd_strap_board board (.i_load(load), .i_req(req), .i_tft(ptype), .o_straps(straps));
	scd_strap_decode DUT (.i_clk(i_clk), .i_srst(i_srst), .i_auto_setup_strap(straps[10]),
		.i_drive_strength_strap(straps[9]), .i_clock_polarity_strap(straps[8]),
		.i_panel_resolution_strap(straps[7:5]), .i_addressing_mode_strap(straps[4]),
		.i_host_bus_select_strap(straps[3:2]), .i_line_clock_ratio_strap(straps[1:0]),
		.i_colour_depth_field(depth), .i_panel_type_select(ptype), .o_config_valid(valid),
		.o_auto_setup_en(auto_en), .o_panel_resolution(res), .o_panel_width(wid), .o_panel_height(hgt),
		.o_tft_drive_high(drv), .o_tft_change_rising(pol), .o_indirect_addr(ind), .o_host_bus(bus),
		.o_clock_is_tft(tft_o), .o_shift_ratio_log2(rlog), .o_shift_ratio_valid(rv),
		.o_resolution_reserved(rsr), .o_bus_reserved(bsr), .o_ratio_reserved(rar));
	// Expected outputs for a captured bundle and live register settings
	function automatic logic [37:0] expect_of(logic [10:0] s, logic [1:0] d, logic p);
		logic [9:0] w[8] = '{10'h0, 10'h140, 10'h1e0, 10'h280, 10'h320, 10'h0, 10'h0, 10'h0};
		logic [9:0] h[8] = '{10'h0, 10'h0f0, 10'h110, 10'h1e0, 10'h1e0, 10'h0, 10'h0, 10'h0};
		logic a;
		logic bad;
		a = s[10] && s[7:5] != 3'h0 && s[7:5] < 3'h5;
		bad = d == 2'h3 || s[1:0] == 2'h3;
		return {1'b1, a, a ? s[7:5] : 3'h0, w[s[7:5]], h[s[7:5]], s[9] & a, s[8] & a, s[4], s[3:2], p,
			bad ? 3'h0 : 3'h2 + {1'b0, d} + {1'b0, s[1:0]}, !p && !bad, s[10] && !a, s[3:2] == 2'h1, !p && bad};
	endfunction : expect_of
	task automatic check_val(string name, logic [37:0] got, logic [37:0] want);
		cmp_count++;
		if (got !== want) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", name, want, got);
		end
	endtask : check_val
	task automatic print_verdict();
		if (mismatches == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : print_verdict
	// Monitor: oldest note against the outputs at each flagged edge
	always @(posedge i_clk) begin
		if (probe) begin
			check_val("decoded", seen, notes.pop_front());
		end
	end
	// Note one expectation; a spare edge keeps probe from toggling twice
	task automatic post(logic [10:0] s);
		notes.push_back(expect_of(s, depth, ptype));
		probe = 1'b1;
		@(posedge i_clk);
		#1 probe = 1'b0;
		@(posedge i_clk);
		#1;
	endtask : post
	// Main sequence: every code of every field, random other bits
	initial begin
		logic [10:0] s;
		void'($urandom(55202));
		for (int i = 0; i < 24; i++) begin
			req = 11'($urandom);
			req[7:5] = 3'(i);
			req[3:2] = 2'(i);
			req[1:0] = 2'(i / 2);
			ptype = i[0];
			depth = 2'($urandom);
			load = 1'b1;
			i_srst = 1'b1;
			repeat (3) @(posedge i_clk);
			#1 i_srst = 1'b0;
			load = 1'b0;
			s = straps;
			// Bounded wait for the capture
			for (int n = 0; n < 8 && valid !== 1'b1; n++) begin
				@(posedge i_clk);
				#1;
			end
			post(s);
			// Pins moved after capture must be ignored
			req = 11'($urandom);
			load = 1'b1;
			#1 load = 1'b0;
			for (int k = 0; k < 8; k++) begin
				depth = 2'(k);
				ptype = k[2];
				post(s);
			end
		end
		print_verdict();
	end
	// Watchdog: run needs about 3 us
	initial begin
		#20000;
		mismatches++;
		print_verdict();
	end
endmodule : tb_top
